// ==== common/wdit_pkg.sv ====
/*
  package: register map, field positions, reset values and timing counts for the watchdog interval timer.
  assumes: used by every design file of the block except the tick interface, referenced with full package scope.
*/
package wdit_pkg;

  // register word addresses on the plain register port
  localparam logic [31:0] ADDR_CONTROL  = 32'h53000000;
  localparam logic [31:0] ADDR_RELOAD   = 32'h53000004;
  localparam logic [31:0] ADDR_COUNT    = 32'h53000008;
  localparam logic [31:0] ADDR_IRQ_STAT = 32'h5300000C;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h53000010;

  // control field positions
  localparam int CTL_PRESC_HI = 15;
  localparam int CTL_PRESC_LO = 8;
  localparam int CTL_ENABLE   = 5;
  localparam int CTL_DIV_HI   = 4;
  localparam int CTL_DIV_LO   = 3;
  localparam int CTL_IRQ_EN   = 2;
  localparam int CTL_RST_EN   = 0;

  // reset values
  localparam logic [15:0] CONTROL_RESET = 16'h8021;
  localparam logic [15:0] RELOAD_RESET  = 16'h8000;
  localparam logic [15:0] COUNT_RESET   = 16'h8000;

  // status bits: time-out and reset-issued events
  localparam int STAT_TIMEOUT = 0;
  localparam int STAT_RESET   = 1;
  localparam int STAT_WIDTH   = 2;

  // system reset pulse length in peripheral clock cycles
  localparam int RESET_PULSE_CYCLES = 128;

  // post divider factors selected by control bits 4:3
  localparam int DIV_FACTOR_16  = 16;
  localparam int DIV_FACTOR_32  = 32;
  localparam int DIV_FACTOR_64  = 64;
  localparam int DIV_FACTOR_128 = 128;

  // divider select encodings
  typedef enum logic [1:0] {
    WDIT_DIV16  = 2'h0,
    WDIT_DIV32  = 2'h1,
    WDIT_DIV64  = 2'h2,
    WDIT_DIV128 = 2'h3
  } wdit_div_t;

endpackage

// ==== common/wdit_tick_if.sv ====
/*
  interface: carries the tick setup and the resulting tick between the top and the tick generator.
  assumes: one clock domain, driven by the watchdog top.
*/
`timescale 1ns/100ps
interface wdit_tick_if;
  logic       run;
  logic [7:0] presc;
  logic [1:0] div_sel;
  logic       tick;

  modport ctrl (output run, output presc, output div_sel, input tick);
  modport gen  (input run, input presc, input div_sel, output tick);
endinterface

// ==== src/wdit_tick_gen.sv ====
/*
  module: prescaler and post divider making one tick per counter step.
  assumes: setup inputs are registers on the same clock; synchronous active-low reset.
*/
`timescale 1ns/100ps
module wdit_tick_gen (
  // clock and reset
  input  wire logic  mclk_i,
  input  wire logic  reset_n_i,
  // setup and tick
  wdit_tick_if.gen   tk
);

  logic [7:0] presc_cnt;
  logic [6:0] div_cnt;
  logic       presc_wrap;
  logic       div_wrap;

  // division factor minus one as a 7-bit limit
  function automatic logic [6:0] div_limit(input logic [1:0] sel);
    case (sel)
      wdit_pkg::WDIT_DIV16:  div_limit = 7'(wdit_pkg::DIV_FACTOR_16 - 1);
      wdit_pkg::WDIT_DIV32:  div_limit = 7'(wdit_pkg::DIV_FACTOR_32 - 1);
      wdit_pkg::WDIT_DIV64:  div_limit = 7'(wdit_pkg::DIV_FACTOR_64 - 1);
      default:               div_limit = 7'(wdit_pkg::DIV_FACTOR_128 - 1);
    endcase
  endfunction

  assign presc_wrap = (presc_cnt >= tk.presc);
  assign div_wrap   = (div_cnt >= div_limit(tk.div_sel));

  // prescaler: one wrap every presc+1 clocks
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || !tk.run) begin
      presc_cnt <= 8'h00;
    end else if (presc_wrap) begin
      presc_cnt <= 8'h00; // RULE13
    end else begin
      presc_cnt <= presc_cnt + 8'h01;
    end
  end

  // post divider counts prescaler wraps, >= guards a shrunk setting
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || !tk.run) begin
      div_cnt <= 7'h00;
    end else if (presc_wrap) begin
      div_cnt <= div_wrap ? 7'h00 : div_cnt + 7'h01; // RULE4
    end
  end

  // one-cycle tick after (presc+1)*factor clocks
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      tk.tick <= 1'b0;
    end else begin
      tk.tick <= tk.run && presc_wrap && div_wrap; // RULE13
    end
  end

endmodule

// ==== src/wdit_reset_pulse.sv ====
/*
  module: stretches a time-out trigger into a fixed-length system reset pulse.
  assumes: trigger is a one-cycle pulse on the same clock.
*/
`timescale 1ns/100ps
module wdit_reset_pulse #(
  parameter int PULSE_CYCLES = wdit_pkg::RESET_PULSE_CYCLES
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic reset_n_i,
  // trigger and pulse
  input  wire logic trigger_i,
  output logic      pulse_o
);

  logic [7:0] left;

  // a trigger during a pulse restarts the full length
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      left    <= 8'h00;
      pulse_o <= 1'b0;
    end else if (trigger_i) begin
      left    <= 8'(PULSE_CYCLES - 1);
      pulse_o <= 1'b1; // RULE12
    end else if (left != 8'h00) begin
      left    <= left - 8'h01;
      pulse_o <= 1'b1;
    end else begin
      pulse_o <= 1'b0;
    end
  end

  pulse_len_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE12
    $rose(pulse_o) && !trigger_i |-> pulse_o [*8])
    else $error("reset pulse ended too early");

endmodule

// ==== src/wdit_top.sv ====
/*
  module: watchdog interval timer top: registers, 16-bit down counter, interrupt and reset pulse.
  assumes: plain register port with read data one cycle after the read strobe;
           core_debug_acknowledge arrives from another domain and is synchronised here.
*/
// What this block does
// [RULE1] 8-bit prescaler field bits 15:8, reset 0x80
// [RULE2] software keeps bits 7:6 and 1 zero
// [RULE3] bit 5 starts/stops counter, reset 1
// [RULE4] bits 4:3 select divide 16/32/64/128
// [RULE5] bit 2 enables time-out interrupt, reset 0
// [RULE6] bit 0 enables reset on time-out
// [RULE7] interval timer: irq on, reset off
// [RULE8] enabling does not load reload value
// [RULE9] each time-out reloads counter from reload
// [RULE10] reload register 16 bits, reset 0x8000
// [RULE11] count register reads live, writes load
// [RULE12] reset output held 128 clock cycles
// [RULE13] tick period (prescaler+1) times divider
// [RULE14] debug acknowledge suppresses reset output
// [RULE15] decrement per tick, irq pulse at time-out
`timescale 1ns/100ps
module wdit_top (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  // register port
  input  wire logic [31:0] reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // core debug state
  input  wire logic        core_debug_acknowledge_i,
  // events out
  output logic             irq_o,
  output logic             timeout_irq_pulse_o,
  output logic             sys_reset_o
);

  logic [15:0] watchdog_control;
  logic [15:0] watchdog_reload_value;
  logic [15:0] watchdog_current_count;
  logic [wdit_pkg::STAT_WIDTH-1:0] irq_status;
  logic [wdit_pkg::STAT_WIDTH-1:0] irq_mask;
  logic        dbg_meta;
  logic        dbg_sync;
  logic        timeout;
  logic        reset_fire;
  logic        rst_pulse;
  logic        wr_control;
  logic        wr_reload;
  logic        wr_count;
  logic        wr_stat;
  logic        wr_mask;
  logic [wdit_pkg::STAT_WIDTH-1:0] next_irq_status;
  logic [wdit_pkg::STAT_WIDTH-1:0] events;
  logic [15:0] rst_run;

  wdit_tick_if tk ();

  // address compare shared by every write decode
  function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
    hit = (a == b);
  endfunction

  assign wr_control = reg_wr_i && hit(reg_addr_i, wdit_pkg::ADDR_CONTROL);
  assign wr_reload  = reg_wr_i && hit(reg_addr_i, wdit_pkg::ADDR_RELOAD);
  assign wr_count   = reg_wr_i && hit(reg_addr_i, wdit_pkg::ADDR_COUNT);
  assign wr_stat    = reg_wr_i && hit(reg_addr_i, wdit_pkg::ADDR_IRQ_STAT);
  assign wr_mask    = reg_wr_i && hit(reg_addr_i, wdit_pkg::ADDR_IRQ_MASK);

  // control register; every field stored as written, reserved bits included
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      watchdog_control <= wdit_pkg::CONTROL_RESET; // RULE1 RULE3 RULE5 RULE6
    end else if (wr_control) begin
      watchdog_control <= reg_wdata_i[15:0]; // RULE1
    end
  end

  // reload register
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      watchdog_reload_value <= wdit_pkg::RELOAD_RESET; // RULE10
    end else if (wr_reload) begin
      watchdog_reload_value <= reg_wdata_i[15:0]; // RULE10
    end
  end

  // tick generator setup
  assign tk.run     = watchdog_control[wdit_pkg::CTL_ENABLE]; // RULE3
  assign tk.presc   = watchdog_control[wdit_pkg::CTL_PRESC_HI:wdit_pkg::CTL_PRESC_LO];
  assign tk.div_sel = watchdog_control[wdit_pkg::CTL_DIV_HI:wdit_pkg::CTL_DIV_LO];

  wdit_tick_gen u_tick (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .tk        (tk)
  );

  // time-out is a tick seen at count zero
  assign timeout = tk.tick && (watchdog_current_count == 16'h0000);

  // counter: software write wins, enabling alone never loads reload
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      watchdog_current_count <= wdit_pkg::COUNT_RESET; // RULE11
    end else if (wr_count) begin
      watchdog_current_count <= reg_wdata_i[15:0]; // RULE11 RULE8
    end else if (timeout) begin
      watchdog_current_count <= watchdog_reload_value; // RULE9
    end else if (tk.tick) begin
      watchdog_current_count <= watchdog_current_count - 16'h0001; // RULE15
    end
  end

  // debug acknowledge synchroniser, second stage is the only reader of the first
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      dbg_meta <= 1'b0;
      dbg_sync <= 1'b0;
    end else begin
      dbg_meta <= core_debug_acknowledge_i;
      dbg_sync <= dbg_meta;
    end
  end

  // reset only when enabled and the core is not halted in debug
  assign reset_fire = timeout && watchdog_control[wdit_pkg::CTL_RST_EN] && !dbg_sync; // RULE6 RULE14

  wdit_reset_pulse #(
    .PULSE_CYCLES (wdit_pkg::RESET_PULSE_CYCLES)
  ) u_rst (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .trigger_i (reset_fire),
    .pulse_o   (rst_pulse)
  );

  // registered copy keeps the output straight from a flip-flop
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      sys_reset_o <= 1'b0;
    end else begin
      sys_reset_o <= rst_pulse; // RULE12
    end
  end

  // time-out interrupt pulse, gated by the control enable
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      timeout_irq_pulse_o <= 1'b0;
    end else begin
      timeout_irq_pulse_o <= timeout && watchdog_control[wdit_pkg::CTL_IRQ_EN]; // RULE5 RULE15
    end
  end

  // sticky status: set beats write-one-to-clear in the same cycle
  always_comb begin
    events = '0;
    events[wdit_pkg::STAT_TIMEOUT] = timeout && watchdog_control[wdit_pkg::CTL_IRQ_EN]; // RULE5
    events[wdit_pkg::STAT_RESET]   = reset_fire;
    next_irq_status = irq_status;
    if (wr_stat) begin
      next_irq_status = irq_status & ~reg_wdata_i[wdit_pkg::STAT_WIDTH-1:0];
    end
    next_irq_status = next_irq_status | events;
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      irq_status <= '0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // mask register, a one lets the status bit through
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      irq_mask <= '0;
    end else if (wr_mask) begin
      irq_mask <= reg_wdata_i[wdit_pkg::STAT_WIDTH-1:0];
    end
  end

  // level interrupt, registered from the next status so it changes in the same cycle as the status
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(next_irq_status & irq_mask);
    end
  end

  // read data valid the cycle after the strobe, zero elsewhere and for unmapped addresses
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        wdit_pkg::ADDR_CONTROL:  reg_rdata_o <= {16'h0000, watchdog_control};
        wdit_pkg::ADDR_RELOAD:   reg_rdata_o <= {16'h0000, watchdog_reload_value};
        wdit_pkg::ADDR_COUNT:    reg_rdata_o <= {16'h0000, watchdog_current_count}; // RULE11
        wdit_pkg::ADDR_IRQ_STAT: reg_rdata_o <= {30'h00000000, irq_status};
        wdit_pkg::ADDR_IRQ_MASK: reg_rdata_o <= {30'h00000000, irq_mask};
        default:                 reg_rdata_o <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end

  // assertions
  count_dec_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE15
    tk.tick && !wr_count && watchdog_current_count != 16'h0000
      |=> watchdog_current_count == $past(watchdog_current_count) - 16'h0001)
    else $error("counter did not step down on a tick");

  reload_on_timeout_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE9
    timeout && !wr_count |=> watchdog_current_count == $past(watchdog_reload_value))
    else $error("counter not reloaded at time-out");

  enable_no_load_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE8
    wr_control && !wr_count && !tk.tick |=> watchdog_current_count == $past(watchdog_current_count))
    else $error("control write changed the counter");

  stopped_hold_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE3
    !tk.run && !wr_count ##1 !tk.run && !wr_count |-> $stable(watchdog_current_count))
    else $error("counter moved while disabled");

  rst_out_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE6
    reset_fire |-> ##2 sys_reset_o [*8])
    else $error("reset output missing after time-out");

  no_rst_off_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE6
    timeout && !watchdog_control[wdit_pkg::CTL_RST_EN] && !sys_reset_o && !rst_pulse |=> !rst_pulse)
    else $error("reset issued while reset function off");

  dbg_block_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE14
    timeout && dbg_sync && !rst_pulse |=> !rst_pulse)
    else $error("reset fired during debug");

  irq_pulse_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE5
    timeout |=> timeout_irq_pulse_o == $past(watchdog_control[wdit_pkg::CTL_IRQ_EN]))
    else $error("interrupt pulse does not follow enable");

  read_count_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE11
    reg_rd_i && reg_addr_i == wdit_pkg::ADDR_COUNT |=> reg_rdata_o[15:0] == $past(watchdog_current_count))
    else $error("count read returned wrong value");

  reset_ctl_a: assert property (@(posedge mclk_i) // RULE1
    !reset_n_i |=> watchdog_control == wdit_pkg::CONTROL_RESET)
    else $error("control reset value wrong");

  // register port writes land at the strobe edge
  count_write_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE11
    wr_count |=> watchdog_current_count == $past(reg_wdata_i[15:0]))
    else $error("count write did not load the counter");

  reload_write_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE10
    wr_reload |=> watchdog_reload_value == $past(reg_wdata_i[15:0]))
    else $error("reload write did not land");

  presc_write_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE1
    wr_control |=> tk.presc == $past(reg_wdata_i[wdit_pkg::CTL_PRESC_HI:wdit_pkg::CTL_PRESC_LO]))
    else $error("prescaler field not stored");

  mask_write_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    wr_mask |=> irq_mask == $past(reg_wdata_i[wdit_pkg::STAT_WIDTH-1:0]))
    else $error("mask write did not land");

  read_reload_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE10
    reg_rd_i && reg_addr_i == wdit_pkg::ADDR_RELOAD |=> reg_rdata_o[15:0] == $past(watchdog_reload_value))
    else $error("reload read returned wrong value");

  rdata_idle_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    !reg_rd_i |=> reg_rdata_o == 32'h00000000)
    else $error("read data not zero outside a read");

  // tick spacing: the smallest factor keeps ticks at least 16 clocks apart
  tick_gap_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE13
    tk.tick |=> (!tk.tick) [*8])
    else $error("ticks closer than the divider allows");

  // sticky status and level interrupt
  set_wins_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE15
    timeout && watchdog_control[wdit_pkg::CTL_IRQ_EN] |=> irq_status[wdit_pkg::STAT_TIMEOUT])
    else $error("time-out status not set");

  status_hold_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    irq_status[wdit_pkg::STAT_TIMEOUT] && !wr_stat |=> irq_status[wdit_pkg::STAT_TIMEOUT])
    else $error("status bit dropped without a clear");

  status_clear_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    wr_stat && reg_wdata_i[wdit_pkg::STAT_TIMEOUT] && !timeout |=> !irq_status[wdit_pkg::STAT_TIMEOUT])
    else $error("status bit not cleared by a one");

  irq_level_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    |(irq_status & irq_mask) && $stable(irq_mask) |-> irq_o)
    else $error("interrupt low with unmasked status");

  // run length of the reset output, for checking only; saturates so a stuck pulse cannot wrap
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rst_run <= 16'h0000;
    end else if (sys_reset_o && rst_run != 16'hFFFF) begin
      rst_run <= rst_run + 16'h0001;
    end else if (!sys_reset_o) begin
      rst_run <= 16'h0000;
    end
  end

  rst_len_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE12
    $fell(sys_reset_o) |-> rst_run >= 16'(wdit_pkg::RESET_PULSE_CYCLES))
    else $error("reset output shorter than its full length");

  sys_off_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE12
    !rst_pulse |=> !sys_reset_o)
    else $error("reset output without an internal pulse");

endmodule

// ==== sim/wdit_sys_model.sv ====
/*
  holds: far-side model, system reset logic and interrupt controller, measuring what the watchdog sends.
  assumes: one clock shared with the watchdog; the reset request is not fed back, so the run goes on.
*/
`timescale 1ns/100ps
module wdit_sys_model (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  // events from the watchdog
  input  wire logic        sys_reset_i,
  input  wire logic        irq_pulse_i,
  // measurements
  output logic      [31:0] pulse_count_o,
  output logic      [31:0] pulse_gap_o,
  output logic      [31:0] rst_count_o,
  output logic      [31:0] rst_len_o
);
  logic [31:0] cyc;
  logic [31:0] last_pulse;
  logic [31:0] run_len;
  logic        rst_q;

  // request spacing and reset pulse length, counted in clock cycles
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      cyc           <= 32'h0;
      last_pulse    <= 32'h0;
      run_len       <= 32'h0;
      rst_q         <= 1'b0;
      pulse_count_o <= 32'h0;
      pulse_gap_o   <= 32'h0;
      rst_count_o   <= 32'h0;
      rst_len_o     <= 32'h0;
    end else begin
      cyc   <= cyc + 32'h1;
      rst_q <= sys_reset_i;
      if (irq_pulse_i) begin
        pulse_count_o <= pulse_count_o + 32'h1;
        pulse_gap_o   <= cyc - last_pulse;
        last_pulse    <= cyc;
      end
      if (sys_reset_i) begin
        run_len <= rst_q ? run_len + 32'h1 : 32'h1;
      end
      if (sys_reset_i && !rst_q) begin
        rst_count_o <= rst_count_o + 32'h1;
      end
      if (!sys_reset_i && rst_q) begin
        rst_len_o <= run_len;
      end
    end
  end
endmodule

// ==== sim/wdit_top_test.sv ====
/*
  holds: self-checking bench for the watchdog top, register tasks and timed scenarios.
  assumes: 20 MHz clock; the far-side model only measures, it never stalls the block.
*/
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module wdit_top_test;
  logic        mclk_i;
  logic        reset_n_i;
  logic [31:0] reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [31:0] reg_rdata_o;
  logic        dbg;
  logic        irq;
  logic        tpulse;
  logic        sysrst;
  logic [31:0] pulse_count;
  logic [31:0] pulse_gap;
  logic [31:0] rst_count;
  logic [31:0] rst_len;
  logic [31:0] d;
  logic [31:0] b;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cycles = 0;

  wdit_top dut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .core_debug_acknowledge_i(dbg), .irq_o(irq), .timeout_irq_pulse_o(tpulse), .sys_reset_o(sysrst));

  wdit_sys_model sys (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .sys_reset_i(sysrst), .irq_pulse_i(tpulse),
    .pulse_count_o(pulse_count), .pulse_gap_o(pulse_gap), .rst_count_o(rst_count), .rst_len_o(rst_len));

  // 50 ns period
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  task automatic wr_reg(input logic [31:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [31:0] a, output logic [31:0] v);
    @(posedge mclk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask

  task automatic wait_pulses(input int n);
    int i;
    i = 0;
    b = pulse_count;
    while (pulse_count < b + n && i < 5000) begin
      @(posedge mclk_i);
      i++;
    end
    // a wait that runs out is a failure, not a quiet pass
    if (i >= 5000) n_mismatch++;
  endtask

  task automatic end_sim();
    $display("mismatches %0d of %0d checks", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // hang guard, well above the longest scenario
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      end_sim();
    end
  end

  initial begin
    int i;
    reset_n_i = 1'b0; reg_addr_i = 32'h0; reg_wdata_i = 32'h0; reg_wr_i = 1'b0; reg_rd_i = 1'b0; dbg = 1'b0;
    repeat (8) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    // reset values and an unmapped place
    rd_reg(wdit_pkg::ADDR_CONTROL, d); `CHK("control", 32'h00008021, d)
    rd_reg(wdit_pkg::ADDR_RELOAD, d); `CHK("reload", 32'h00008000, d)
    rd_reg(wdit_pkg::ADDR_COUNT, d); `CHK("count", 32'h00008000, d)
    rd_reg(wdit_pkg::ADDR_IRQ_STAT, d); `CHK("status", 32'h00000000, d)
    rd_reg(32'h53000014, d); `CHK("unmapped", 32'h00000000, d)
    // reserved bits kept zero by every write below
    wr_reg(wdit_pkg::ADDR_CONTROL, 32'h0000FF00);
    rd_reg(wdit_pkg::ADDR_CONTROL, d); `CHK("prescaler", 32'h0000FF00, d)
    // count loaded before enabling, enable must not reload
    wr_reg(wdit_pkg::ADDR_CONTROL, 32'h00000000);
    wr_reg(wdit_pkg::ADDR_COUNT, 32'h00000100);
    wr_reg(wdit_pkg::ADDR_CONTROL, 32'h00000020);
    rd_reg(wdit_pkg::ADDR_COUNT, d); `CHK("count kept", 32'h00000100, d)
    repeat (64) @(posedge mclk_i);
    rd_reg(wdit_pkg::ADDR_COUNT, d); `CHK("counting", 1'b1, (d < 32'h100 && d > 32'hF0))
    // every divider with prescaler 1: gap is (3+1)*(1+1)*div
    wr_reg(wdit_pkg::ADDR_CONTROL, 32'h00000000);
    wr_reg(wdit_pkg::ADDR_RELOAD, 32'h00000003);
    for (int s = 0; s < 4; s++) begin
      wr_reg(wdit_pkg::ADDR_COUNT, 32'h00000003);
      wr_reg(wdit_pkg::ADDR_CONTROL, 32'h00000124 | (s << 3));
      wait_pulses(2);
      `CHK("gap", 32'h80 << s, pulse_gap)
      wr_reg(wdit_pkg::ADDR_CONTROL, 32'h00000000);
    end
    // time-outs with interrupt and reset both off
    wr_reg(wdit_pkg::ADDR_RELOAD, 32'h00000001);
    wr_reg(wdit_pkg::ADDR_COUNT, 32'h00000001);
    b = pulse_count;
    wr_reg(wdit_pkg::ADDR_CONTROL, 32'h00000020);
    repeat (300) @(posedge mclk_i);
    `CHK("no irq pulse", b, pulse_count)
    `CHK("no reset", 32'h0, rst_count)
    wr_reg(wdit_pkg::ADDR_CONTROL, 32'h00000000);
    // sticky status, mask and clear
    rd_reg(wdit_pkg::ADDR_IRQ_STAT, d); `CHK("status set", 32'h00000001, d)
    `CHK("irq masked", 1'b0, irq)
    wr_reg(wdit_pkg::ADDR_IRQ_MASK, 32'h00000001);
    rd_reg(wdit_pkg::ADDR_IRQ_MASK, d); `CHK("mask", 32'h00000001, d)
    repeat (2) @(posedge mclk_i);
    `CHK("irq on", 1'b1, irq)
    wr_reg(wdit_pkg::ADDR_IRQ_STAT, 32'h00000001);
    repeat (2) @(posedge mclk_i);
    `CHK("irq off", 1'b0, irq)
    rd_reg(wdit_pkg::ADDR_IRQ_STAT, d); `CHK("status clear", 32'h00000000, d)
    // reset pulse; reload spacing longer than the pulse avoids a restart
    wr_reg(wdit_pkg::ADDR_RELOAD, 32'h00000014);
    wr_reg(wdit_pkg::ADDR_COUNT, 32'h00000002);
    wr_reg(wdit_pkg::ADDR_CONTROL, 32'h00000025);
    i = 0;
    while (rst_count == 32'h0 && i < 2000) begin
      @(posedge mclk_i);
      i++;
    end
    while (sysrst === 1'b1 && i < 2000) begin
      @(posedge mclk_i);
      i++;
    end
    if (i >= 2000) n_mismatch++;
    repeat (2) @(posedge mclk_i);
    `CHK("reset length", 32'd128, rst_len)
    rd_reg(wdit_pkg::ADDR_IRQ_STAT, d); `CHK("status both", 32'h00000003, d)
    // debug acknowledge keeps the reset away but not the interrupt
    @(posedge mclk_i);
    dbg <= 1'b1;
    repeat (4) @(posedge mclk_i);
    d = rst_count;
    wait_pulses(2);
    `CHK("debug pulses", b + 32'h2, pulse_count)
    `CHK("debug no reset", d, rst_count)
    dbg <= 1'b0;
    wr_reg(wdit_pkg::ADDR_CONTROL, 32'h00000000);
    end_sim();
  end
endmodule
